// file: design/tfcb_pkg.sv
// package for the timer flag and control register B block
package tfcb_pkg;
  localparam logic [7:0] TFCB_OFS_CTRL_B = 8'h0b;
  localparam logic [7:0] TFCB_OFS_MASK   = 8'h0c;
  localparam logic [7:0] TFCB_OFS_VALUE  = 8'h0d;
  localparam logic [7:0] TFCB_OFS_CMP    = 8'h0e;
  localparam logic [7:0] TFCB_OFS_CMPH   = 8'h0f;
  localparam logic [7:0] TFCB_OFS_CTRL_A = 8'h10;
  localparam logic [7:0] TFCB_CTRL_B_RST = 8'h00;
  localparam logic [7:0] TFCB_MASK_RST   = 8'h00;
  localparam logic [15:0] TFCB_WORD_RST  = 16'h0000;
  localparam int TFCB_BIT_LCMP = 0;
  localparam int TFCB_BIT_CCMP = 1;
  localparam int TFCB_BIT_LOVF = 2;
  localparam int TFCB_BIT_MOVF = 3;
  localparam int TFCB_BIT_RSVD = 4;
  localparam int TFCB_BIT_POL  = 5;
  localparam int TFCB_BIT_OE   = 6;
  localparam int TFCB_BIT_LIE  = 7;
  localparam logic [7:0] TFCB_FLAG_MASK = 8'h0f;
  localparam logic [7:0] TFCB_RW_MASK   = 8'he0;
  typedef enum logic [0:0] {TFCB_MODE_WIDE = 1'b0, TFCB_MODE_DUAL = 1'b1} tfcb_mode_t;
endpackage

// file: design/tfcb_sync.sv
// two flop synchroniser for a pin level
`timescale 1ns/1ps
module tfcb_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_r;

  // first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// file: design/tfcb_top.sv
// timer flags and control register B with a compact counter core
`timescale 1ns/1ps
module tfcb_top
#(
  // 0 builds the single pin variant
  parameter bit HAS_ALT_PIN = 1'b1
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [15:0]            regRdata,
  // external capture edge pin
  input  wire logic              captPin,
  // alternate output pin
  output logic                   altOutputPin,
  output logic                   altOutputPinOe,
  // interrupt
  output logic                   irq
);
  import tfcb_pkg::*;

  // register state
  logic [7:0]  ctrlB_r;
  logic [7:0]  ctrlB_nxt;
  logic [7:0]  intMask_r;
  logic [7:0]  irqGate;
  logic [15:0] counterValue_r;
  logic [15:0] compareValue_r;
  logic [7:0]  highCompareValue_r;
  logic        runEnable_r;
  logic        captEnable_r;
  tfcb_mode_t  dualByteModeSelect_r;

  // capture pin path
  logic        captSync;
  logic        captPrev_r;
  logic        captEdge;

  // counter core events
  logic        tick;
  logic [7:0]  lowByteCounter;
  logic [7:0]  highByteCounter;
  logic        lowOvf;
  logic        highOvf;
  logic        wideOvf;
  logic        lowMatch;
  logic        highMatch;
  logic        wideMatch;

  // flag set terms and pin path
  logic [7:0]  hwSet;
  logic        waveToggle;
  logic        altEnable;
  logic        wave;
  logic        waveOe;

  // register write decode shared by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // mode decode used by flags, counter, pin and read path
  function automatic logic isDual(input tfcb_mode_t m);
    isDual = (m == TFCB_MODE_DUAL);
  endfunction

  // byte step shared by both halves in dual mode
  function automatic logic [7:0] stepByte(input logic [7:0] b);
    stepByte = b + 8'h01;
  endfunction

  // byte views of the counter
  assign lowByteCounter  = counterValue_r[7:0];
  assign highByteCounter = counterValue_r[15:8];
  // no prescaler: the core steps on every clock while running
  assign tick            = runEnable_r;

  // pin passes two flops before the edge detector
  tfcb_sync u_capt_sync
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (captPin),
    .dout    (captSync)
  );

  // previous level resets to the idle low of the pin, so no false edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      captPrev_r <= 1'b0;
    else
      captPrev_r <= captSync;
  end
  assign captEdge = captEnable_r && captSync && !captPrev_r;

  // overflow and match events of the counter core
  assign lowOvf    = tick && (lowByteCounter == 8'hff);
  assign highOvf   = tick && (highByteCounter == 8'hff);
  assign wideOvf   = tick && (counterValue_r == 16'hffff);
  assign lowMatch  = lowByteCounter == compareValue_r[7:0];
  assign highMatch = highByteCounter == highCompareValue_r;
  assign wideMatch = counterValue_r == compareValue_r;

  // hardware set terms per flag
  always_comb
  begin
    hwSet = 8'h00;
    if (isDual(dualByteModeSelect_r))
    begin
      hwSet[TFCB_BIT_LCMP] = tick && lowMatch;
      hwSet[TFCB_BIT_LOVF] = lowOvf;
      hwSet[TFCB_BIT_MOVF] = highOvf;
      hwSet[TFCB_BIT_CCMP] = (tick && highMatch) || captEdge;
    end
    else
    begin
      // low byte flags carry no meaning in 16-bit mode, never set
      hwSet[TFCB_BIT_MOVF] = wideOvf;
      hwSet[TFCB_BIT_CCMP] = (tick && wideMatch) || captEdge;
    end
  end

  // software write first, hardware set wins over a clearing write
  always_comb
  begin
    ctrlB_nxt = ctrlB_r;
    if (regWr && hit(regAddr, TFCB_OFS_CTRL_B))
      ctrlB_nxt = regWdata[7:0] & (TFCB_FLAG_MASK | TFCB_RW_MASK);
    ctrlB_nxt = ctrlB_nxt | hwSet;
    ctrlB_nxt[TFCB_BIT_RSVD] = 1'b0;
    if (!HAS_ALT_PIN)
      ctrlB_nxt[TFCB_BIT_OE] = 1'b0;
  end

  // every form of reset clears the whole register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrlB_r <= TFCB_CTRL_B_RST;
    else
      ctrlB_r <= ctrlB_nxt;
  end

  // mask register, same layout as the flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      intMask_r <= TFCB_MASK_RST;
    else if (regWr && hit(regAddr, TFCB_OFS_MASK))
      intMask_r <= regWdata[7:0] & TFCB_FLAG_MASK;
  end

  // core control: run, capture enable, mode select
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      runEnable_r          <= 1'b0;
      captEnable_r         <= 1'b0;
      dualByteModeSelect_r <= TFCB_MODE_WIDE;
    end
    else if (regWr && hit(regAddr, TFCB_OFS_CTRL_A))
    begin
      runEnable_r          <= regWdata[0];
      captEnable_r         <= regWdata[1];
      dualByteModeSelect_r <= tfcb_mode_t'(regWdata[2]);
    end
  end

  // counter, halves wrap separately in dual mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      counterValue_r <= TFCB_WORD_RST;
    else if (regWr && hit(regAddr, TFCB_OFS_VALUE))
    begin
      // upper byte is blocked in dual mode
      counterValue_r[7:0] <= regWdata[7:0];
      if (dualByteModeSelect_r == TFCB_MODE_WIDE)
        counterValue_r[15:8] <= regWdata[15:8];
    end
    else if (tick)
    begin
      if (isDual(dualByteModeSelect_r))
      begin
        // both halves step together, each wraps on its own
        counterValue_r[7:0]  <= stepByte(lowByteCounter);
        counterValue_r[15:8] <= stepByte(highByteCounter);
      end
      else
        // one carry chain across both halves
        counterValue_r <= counterValue_r + 16'h0001;
    end
  end

  // compare registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      compareValue_r     <= TFCB_WORD_RST;
      highCompareValue_r <= TFCB_CTRL_B_RST;
    end
    else
    begin
      // low byte doubles as the low compare value in dual mode
      if (regWr && hit(regAddr, TFCB_OFS_CMP))
        compareValue_r <= regWdata;
      if (regWr && hit(regAddr, TFCB_OFS_CMPH))
        highCompareValue_r <= regWdata[7:0];
    end
  end

  // pin toggles on wrap of the selected counter
  assign waveToggle = isDual(dualByteModeSelect_r) ? lowOvf : wideOvf;
  assign altEnable  = HAS_ALT_PIN && ctrlB_r[TFCB_BIT_OE];

  // start level latch lives in the wave module
  tfcb_wave u_wave
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .enable   (altEnable),
    .polarity (ctrlB_r[TFCB_BIT_POL]),
    .toggle   (waveToggle),
    .pinOut   (wave),
    .pinOe    (waveOe)
  );

  // registered pin drive, extra stage keeps outputs on flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      altOutputPin   <= 1'b0;
      altOutputPinOe <= 1'b0;
    end
    else
    begin
      altOutputPin   <= wave;
      altOutputPinOe <= waveOe;
    end
  end

  // low byte sources need the bit 7 enable, the others only the mask
  always_comb
  begin
    irqGate                = intMask_r;
    irqGate[TFCB_BIT_LCMP] = intMask_r[TFCB_BIT_LCMP] && ctrlB_r[TFCB_BIT_LIE];
    irqGate[TFCB_BIT_LOVF] = intMask_r[TFCB_BIT_LOVF] && ctrlB_r[TFCB_BIT_LIE];
  end

  // interrupt level, mask upper bits are zero so control bits never count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(ctrlB_r & irqGate);
  end

  // read data one cycle after the strobe, unmapped reads zero
  // reads have no side effect, flags change only by write or event
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRdata <= TFCB_WORD_RST;
    else if (regRd)
    begin
      unique case (regAddr)
        TFCB_OFS_CTRL_B: regRdata <= {8'h00, ctrlB_r};
        TFCB_OFS_MASK:   regRdata <= {8'h00, intMask_r};
        TFCB_OFS_VALUE:  regRdata <= isDual(dualByteModeSelect_r) ?
                                     {8'h00, lowByteCounter} : counterValue_r;
        TFCB_OFS_CMP:    regRdata <= compareValue_r;
        TFCB_OFS_CMPH:   regRdata <= {8'h00, highCompareValue_r};
        TFCB_OFS_CTRL_A: regRdata <= {13'h0000, dualByteModeSelect_r, captEnable_r, runEnable_r};
        default:         regRdata <= TFCB_WORD_RST;
      endcase
    end
    else
      regRdata <= TFCB_WORD_RST;
  end
endmodule

// file: design/tfcb_wave.sv
// alternate pin waveform generator with latched start polarity
`timescale 1ns/1ps
module tfcb_wave
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic enable,
  input  wire logic polarity,
  input  wire logic toggle,
  // pin
  output logic      pinOut,
  output logic      pinOe
);
  logic enable_r;

  // polarity is only sampled on the enable rise
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable_r <= 1'b0;
      pinOut   <= 1'b0;
      pinOe    <= 1'b0;
    end
    else
    begin
      enable_r <= enable;
      pinOe    <= enable;
      if (enable && !enable_r)
        pinOut <= polarity;
      else if (enable && toggle)
        pinOut <= ~pinOut;
    end
  end
endmodule

// file: test/tfcb_checker.sv
// port level assertions for the timer flags and control register B block
`timescale 1ns/1ps
module tfcb_checker
#(
  parameter bit HAS_ALT_PIN = 1'b1
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  // pins
  input wire logic        captPin,
  input wire logic        altOutputPin,
  input wire logic        altOutputPinOe,
  input wire logic        irq
);
  import tfcb_pkg::*;
  // write to control register B in this cycle
  logic wrB;
  assign wrB = regWr && (regAddr == TFCB_OFS_CTRL_B);
  property p_rdIdle;
    @(posedge clk) disable iff (sys_rst) !$past(regRd) |-> regRdata == 16'h0000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  // no disable here: outputs must be low right after a reset edge
  property p_rstOut;
    @(posedge clk) sys_rst |=> !irq && !altOutputPinOe && !altOutputPin && regRdata == 16'h0000;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("outputs not cleared by reset");
  property p_rdB;
    @(posedge clk) disable iff (sys_rst) regRd && regAddr == TFCB_OFS_CTRL_B |=> regRdata[15:8] == 8'h00 && !regRdata[4];
  endproperty
  a_rdB: assert property (p_rdB) else $error("reserved bits of control B read high");
  property p_unmapped;
    @(posedge clk) disable iff (sys_rst) regRd && regAddr > TFCB_OFS_CTRL_A |=> regRdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oeFollow;
    // register, wave flop and output flop: the pin enable shows three edges after the write
    @(posedge clk) disable iff (sys_rst) wrB |-> ##3 altOutputPinOe == (HAS_ALT_PIN && $past(regWdata[6], 3));
  endproperty
  a_oeFollow: assert property (p_oeFollow) else $error("output enable does not follow bit 6");
  // a fresh rise of the enable must start the pin at the polarity written with it
  property p_polStart;
    @(posedge clk) disable iff (sys_rst) wrB && regWdata[6] && HAS_ALT_PIN ##2 !altOutputPinOe
      |-> ##1 altOutputPinOe && altOutputPin == $past(regWdata[5], 3);
  endproperty
  a_polStart: assert property (p_polStart) else $error("pin start level differs from polarity");
  property p_readBack;
    @(posedge clk) disable iff (sys_rst) wrB ##1 (regRd && regAddr == TFCB_OFS_CTRL_B)
      |=> regRdata[7:5] == {$past(regWdata[7], 2), $past(regWdata[6], 2) & HAS_ALT_PIN, $past(regWdata[5], 2)};
  endproperty
  a_readBack: assert property (p_readBack) else $error("control bits read back wrong");
  property p_noPin;
    @(posedge clk) disable iff (sys_rst) !HAS_ALT_PIN |-> !altOutputPinOe;
  endproperty
  a_noPin: assert property (p_noPin) else $error("pin driven in single pin variant");
endmodule

bind tfcb_top tfcb_checker #(.HAS_ALT_PIN(HAS_ALT_PIN)) u_chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .captPin(captPin),
  .altOutputPin(altOutputPin), .altOutputPinOe(altOutputPinOe), .irq(irq));

// file: test/tfcb_top_tb.sv
// self checking bench for the timer flags and control register B block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module tfcb_top_tb;
  import tfcb_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        captPin = 1'b0;
  logic [15:0] regRdata;
  logic        altOutputPin;
  logic        altOutputPinOe;
  logic        irq;
  int          errors = 0;
  int          comparisons = 0;
  tfcb_top u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .captPin(captPin), .altOutputPin(altOutputPin),
    .altOutputPinOe(altOutputPinOe), .irq(irq));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  // one cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata & m, e)
  endtask
  // let n edges land, then look between edges
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rdChk(TFCB_OFS_CTRL_B, 16'hffff, 16'h0000);
    rdChk(8'h20, 16'hffff, 16'h0000);
    wr(TFCB_OFS_CTRL_B, 16'h00ff);
    rdChk(TFCB_OFS_CTRL_B, 16'hffff, 16'h00ef);
    wr(TFCB_OFS_CTRL_B, 16'h0000);
    rdChk(TFCB_OFS_CTRL_B, 16'hffff, 16'h0000);
  endtask
  // low byte passes 0xff once in 300 cycles, the high byte steps with it and passes 0xff on the same tick
  task automatic t_dual;
    wr(TFCB_OFS_CMP, 16'h0005);
    wr(TFCB_OFS_CTRL_B, 16'h0040);
    wr(TFCB_OFS_CTRL_A, 16'h0005);
    settle(300);
    wr(TFCB_OFS_CTRL_A, 16'h0004);
    rdChk(TFCB_OFS_CTRL_B, 16'h0005, 16'h0005);
    `CHK(altOutputPin, 1'b1)
  endtask
  task automatic t_wide;
    wr(TFCB_OFS_CTRL_A, 16'h0000);
    wr(TFCB_OFS_VALUE, 16'hfff0);
    wr(TFCB_OFS_CMP, 16'hfff8);
    wr(TFCB_OFS_CTRL_B, 16'h0000);
    wr(TFCB_OFS_CTRL_B, 16'h0040);
    wr(TFCB_OFS_CTRL_A, 16'h0001);
    settle(40);
    wr(TFCB_OFS_CTRL_A, 16'h0000);
    rdChk(TFCB_OFS_CTRL_B, 16'h000f, 16'h000a);
    `CHK(altOutputPin, 1'b1)
  endtask
  task automatic t_capt;
    wr(TFCB_OFS_CTRL_B, 16'h0000);
    wr(TFCB_OFS_CTRL_A, 16'h0002);
    captPin <= 1'b1;
    settle(8);
    captPin <= 1'b0;
    rdChk(TFCB_OFS_CTRL_B, 16'h000f, 16'h0002);
  endtask
  task automatic t_irq;
    wr(TFCB_OFS_MASK, 16'h000f);
    wr(TFCB_OFS_CTRL_B, 16'h0001);
    settle(3);
    `CHK(irq, 1'b0)
    wr(TFCB_OFS_CTRL_B, 16'h0081);
    settle(3);
    `CHK(irq, 1'b1)
    wr(TFCB_OFS_MASK, 16'h0000);
    settle(3);
    `CHK(irq, 1'b0)
    wr(TFCB_OFS_MASK, 16'h0008);
    wr(TFCB_OFS_CTRL_B, 16'h0008);
    settle(3);
    `CHK(irq, 1'b1)
    wr(TFCB_OFS_CTRL_B, 16'h0000);
    settle(3);
    `CHK(irq, 1'b0)
    // low overflow also needs bit 7, capture/compare does not
    wr(TFCB_OFS_MASK, 16'h000f);
    wr(TFCB_OFS_CTRL_B, 16'h0004);
    settle(3);
    `CHK(irq, 1'b0)
    wr(TFCB_OFS_CTRL_B, 16'h0002);
    settle(3);
    `CHK(irq, 1'b1)
    wr(TFCB_OFS_CTRL_B, 16'h0000);
  endtask
  // polarity only lands on the pin at an enable rise
  task automatic t_alt;
    wr(TFCB_OFS_CTRL_B, 16'h0020);
    settle(3);
    `CHK(altOutputPinOe, 1'b0)
    wr(TFCB_OFS_CTRL_B, 16'h0060);
    settle(3);
    `CHK({altOutputPinOe, altOutputPin}, 2'b11)
    wr(TFCB_OFS_CTRL_B, 16'h0040);
    settle(3);
    `CHK(altOutputPin, 1'b1)
    wr(TFCB_OFS_CTRL_B, 16'h0000);
    wr(TFCB_OFS_CTRL_B, 16'h0040);
    settle(3);
    `CHK(altOutputPin, 1'b0)
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_dual();
    t_wide();
    t_capt();
    t_irq();
    t_alt();
    close_out();
  end
  // watchdog well beyond the few hundred cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
